/* File: include/twpm_regs.vh */
// register offsets, fields and timing constants of the two-wire pot master
`ifndef TWPM_REGS_VH
`define TWPM_REGS_VH

// controller register offsets (16-bit word address on the local port)
`define TWPM_REG_CTRL      4'h0
`define TWPM_REG_STATUS    4'h1
`define TWPM_REG_RDATA     4'h2
`define TWPM_REG_CFG       4'h3

// control register fields
`define TWPM_CTRL_GO       0
`define TWPM_CTRL_OP_LO    1
`define TWPM_CTRL_OP_HI    3
`define TWPM_CTRL_POT_LO   4
`define TWPM_CTRL_POT_HI   5
`define TWPM_CTRL_DATA_LO  8
`define TWPM_CTRL_DATA_HI  15

// operation codes
`define TWPM_OP_VWRITE     3'h0
`define TWPM_OP_NVWRITE    3'h1
`define TWPM_OP_READ       3'h2
`define TWPM_OP_CS_WRITE   3'h3
`define TWPM_OP_CS_READ    3'h4
`define TWPM_OP_POLL       3'h5

// status register fields
`define TWPM_ST_BUSY       0
`define TWPM_ST_NACK       1
`define TWPM_ST_DONE       2

// slave address fields
`define TWPM_TYPE_CODE     4'h5 // arbitrary value
`define TWPM_SEL_POT       3'h7
`define TWPM_SEL_CSR       3'h2
`define TWPM_DIR_READ      1'b1
`define TWPM_DIR_WRITE     1'b0

// instruction byte fields
`define TWPM_WT_BIT        7
`define TWPM_POT_100       2'h1
`define TWPM_POT_256       2'h2
`define TWPM_POT_RSVD      2'h3
`define TWPM_MAX_TAP_100   8'h63
`define TWPM_MAX_TAP_256   8'hFF

// timing: quarter period of the serial clock and the polling budget
`define TWPM_CLK_HZ        50000000
`define TWPM_SCL_HALF_NS   2500
`define TWPM_SCL_HALF_CYC  ((`TWPM_SCL_HALF_NS * 50) / 1000)
`define TWPM_PROG_MS       5
`define TWPM_POLL_MAX      16'h0100

`endif

/* File: rtl/twpm_bit_engine.v */
// bit level engine: start, stop, byte send/receive with acknowledge
`timescale 1ns/1ps
`include "twpm_regs.vh"

module twpm_bit_engine (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // command
    input  wire [2:0] cmd_i,
    input  wire       cmd_valid_i,
    input  wire [7:0] tx_byte_i,
    input  wire       tx_ack_i,
    output wire       cmd_ready_o,
    output reg  [7:0] rx_byte_o,
    output reg        rx_ack_o,
    // bus pins
    input  wire       sda_i,
    output reg        sda_o,
    output wire       sda_oe_o,
    output reg        scl_o,
    output wire       scl_oe_o
);

    localparam C_START = 3'h1;
    localparam C_STOP  = 3'h2;
    localparam C_WRITE = 3'h3;
    localparam C_READ  = 3'h4;
    localparam [31:0] HALF_W = `TWPM_SCL_HALF_CYC;
    localparam [7:0]  HALF   = HALF_W[7:0];

    localparam S_IDLE = 3'h0;
    localparam S_ST   = 3'h1;
    localparam S_SP   = 3'h2;
    localparam S_BIT  = 3'h3;

    reg  [2:0] state;
    reg  [7:0] cnt;
    reg  [1:0] phase;
    reg  [3:0] bitn;
    reg  [8:0] shreg;
    reg        sda_s1;
    reg        sda_s2;
    wire       tick;

    assign tick        = (cnt == 8'h00);
    assign cmd_ready_o = (state == S_IDLE);
    // open drain: drive only to pull low
    assign sda_oe_o    = ~sda_o;
    assign scl_oe_o    = ~scl_o;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state     <= S_IDLE;
            cnt       <= 8'h00;
            phase     <= 2'h0;
            bitn      <= 4'h0;
            shreg     <= 9'h1FF;
            sda_o     <= 1'b1;
            scl_o     <= 1'b1;
            rx_byte_o <= 8'h00;
            rx_ack_o  <= 1'b1;
        end else begin
            cnt <= tick ? HALF - 8'h01 : cnt - 8'h01;
            case (state)
                S_IDLE: begin
                    phase <= 2'h0;
                    bitn  <= 4'h0;
                    if (cmd_valid_i) begin
                        cnt <= HALF - 8'h01;
                        if (cmd_i == C_START)
                            state <= S_ST;
                        else if (cmd_i == C_STOP)
                            state <= S_SP;
                        else if (cmd_i == C_WRITE) begin
                            state <= S_BIT;
                            shreg <= {tx_byte_i, 1'b1};
                        end else begin
                            state <= S_BIT;
                            shreg <= {8'hFF, tx_ack_i};
                        end
                    end
                end
                // sda high, scl high, then sda falls, then scl falls
                S_ST: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: begin
                            sda_o <= 1'b1;
                            scl_o <= 1'b1;
                        end
                        2'h1: sda_o <= 1'b0;
                        default: begin
                            scl_o <= 1'b0;
                            state <= S_IDLE;
                        end
                    endcase
                end
                // sda low while scl low, scl rises, then sda rises
                S_SP: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: sda_o <= 1'b0;
                        2'h1: scl_o <= 1'b1;
                        default: begin
                            sda_o <= 1'b1;
                            state <= S_IDLE;
                        end
                    endcase
                end
                // nine bits, data only changes with scl low
                S_BIT: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: sda_o <= shreg[8];
                        2'h1: scl_o <= 1'b1;
                        2'h2: shreg <= {shreg[7:0], sda_s2};
                        default: begin
                            scl_o <= 1'b0;
                            bitn  <= bitn + 4'h1;
                            phase <= 2'h0;
                            if (bitn == 4'h8) begin
                                state     <= S_IDLE;
                                sda_o     <= 1'b1;
                                rx_ack_o  <= shreg[0];
                                rx_byte_o <= shreg[8:1];
                            end
                        end
                    endcase
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule // twpm_bit_engine

/* File: rtl/twpm_master.v */
// host-side controller for the two-wire dual potentiometer slave
// Functional notes
// - data line changes only while clock is low, except start/stop
// - start is data falling while clock high; each command starts so
// - every transaction ends with stop, after transmitter releases data
// - transmitter releases data after eight bits; receiver acks ninth clock
// - read: master acks to continue, nacks last byte then stops
// - address top four bits carry the fixed type code
// - write latch enable must be set before any wiper write
// - poll with valid address; ack means programming finished
// - wiper write is address, instruction, data bytes in order
// - wiper read: write address, instruction, restart, read address
`timescale 1ns/1ps
`include "twpm_regs.vh"

module twpm_master (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // register port
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // bus pins
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_o,
    output wire        scl_o,
    output wire        scl_oe_o
);

    localparam E_START = 3'h1;
    localparam E_STOP  = 3'h2;
    localparam E_WRITE = 3'h3;
    localparam E_READ  = 3'h4;

    localparam S_IDLE  = 4'h0;
    localparam S_START = 4'h1;
    localparam S_ADDR  = 4'h2;
    localparam S_INSTR = 4'h3;
    localparam S_DATA  = 4'h4;
    localparam S_RSTRT = 4'h5;
    localparam S_RADDR = 4'h6;
    localparam S_RBYTE = 4'h7;
    localparam S_STOP  = 4'h8;
    localparam S_WAIT  = 4'h9;

    ////////////////////////////////////////////////////////////////////////
    // slave address builder
    function [7:0] slave_addr;
        input [2:0] sel;
        input       dir;
        begin
            slave_addr = {`TWPM_TYPE_CODE, sel, dir};
        end
    endfunction

    // clamp to the selected pot's top tap so the word matches the slave
    function [7:0] clamp_tap;
        input [1:0] pot;
        input [7:0] val;
        begin
            if (pot == `TWPM_POT_100 && val > `TWPM_MAX_TAP_100)
                clamp_tap = `TWPM_MAX_TAP_100;
            else
                clamp_tap = val;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [2:0]  op;
    reg  [1:0]  pot;
    reg  [7:0]  data;
    reg         busy;
    reg         nack;
    reg         done;
    reg  [7:0]  rbyte;
    reg  [15:0] polls;
    reg  [15:0] poll_max;
    reg         sent;
    reg  [2:0]  e_cmd;
    reg  [7:0]  e_tx;
    reg         e_valid;
    wire        e_ready;
    wire [7:0]  e_rx;
    wire        e_ack;
    wire        is_cs;
    wire        is_rd;
    wire        go;

    assign is_cs = (op == `TWPM_OP_CS_WRITE) || (op == `TWPM_OP_CS_READ);
    assign is_rd = (op == `TWPM_OP_READ) || (op == `TWPM_OP_CS_READ);
    assign go    = wr_i && addr_i == `TWPM_REG_CTRL
                   && wdata_i[`TWPM_CTRL_GO] && !busy;

    twpm_bit_engine u_eng (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .cmd_i       (e_cmd),
        .cmd_valid_i (e_valid),
        .tx_byte_i   (e_tx),
        .tx_ack_i    (1'b1),
        .cmd_ready_o (e_ready),
        .rx_byte_o   (e_rx),
        .rx_ack_o    (e_ack),
        .sda_i       (sda_i),
        .sda_o       (sda_o),
        .sda_oe_o    (sda_oe_o),
        .scl_o       (scl_o),
        .scl_oe_o    (scl_oe_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // engine command per state; issued once, result taken when ready again
    always @* begin
        e_cmd = E_START;
        e_tx  = 8'hFF;
        case (state)
            S_START: e_cmd = E_START;
            S_RSTRT: e_cmd = E_START;
            S_ADDR: begin
                e_cmd = E_WRITE;
                if (op == `TWPM_OP_POLL)
                    e_tx = slave_addr(`TWPM_SEL_POT,
                                      `TWPM_DIR_WRITE);
                else if (is_cs) // latch is set through this path
                    e_tx = slave_addr(`TWPM_SEL_CSR,
                        op == `TWPM_OP_CS_READ ? `TWPM_DIR_READ
                                               : `TWPM_DIR_WRITE);
                else
                    e_tx = slave_addr(`TWPM_SEL_POT, `TWPM_DIR_WRITE);
            end
            S_INSTR: begin
                e_cmd = E_WRITE;
                e_tx  = {op == `TWPM_OP_NVWRITE, 5'h00, pot};
            end
            S_DATA: begin
                e_cmd = E_WRITE;
                e_tx  = is_cs ? data : clamp_tap(pot, data);
            end
            S_RADDR: begin
                e_cmd = E_WRITE;
                e_tx  = slave_addr(`TWPM_SEL_POT, `TWPM_DIR_READ);
            end
            S_RBYTE: e_cmd = E_READ;
            S_STOP:  e_cmd = E_STOP;
            default: e_cmd = E_START;
        endcase
    end

    // flow of one command; a refused byte goes straight to stop
    always @* begin
        next_state = state;
        case (state)
            S_IDLE:  next_state = S_IDLE;
            S_START: next_state = S_ADDR;
            S_ADDR: begin
                if (e_ack)
                    next_state = S_STOP;
                else if (op == `TWPM_OP_POLL)
                    next_state = S_STOP;
                else if (is_cs && is_rd)
                    next_state = S_RBYTE;
                else if (is_cs)
                    next_state = S_DATA;
                else
                    next_state = S_INSTR;
            end
            S_INSTR: begin
                if (e_ack)
                    next_state = S_STOP;
                else if (op == `TWPM_OP_READ)
                    next_state = S_RSTRT;
                else
                    next_state = S_DATA;
            end
            S_DATA:  next_state = S_STOP;
            S_RSTRT: next_state = S_RADDR;
            S_RADDR: next_state = e_ack ? S_STOP : S_RBYTE;
            S_RBYTE: next_state = S_STOP;
            S_STOP:  next_state = S_WAIT;
            S_WAIT:  next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state    <= S_IDLE;
            op       <= `TWPM_OP_VWRITE;
            pot      <= `TWPM_POT_100;
            data     <= 8'h00;
            busy     <= 1'b0;
            nack     <= 1'b0;
            done     <= 1'b0;
            rbyte    <= 8'h00;
            polls    <= 16'h0000;
            poll_max <= `TWPM_POLL_MAX;
            sent     <= 1'b0;
            e_valid  <= 1'b0;
        end else begin
            e_valid <= 1'b0;
            if (wr_i && addr_i == `TWPM_REG_CFG)
                poll_max <= wdata_i;
            if (rd_i && addr_i == `TWPM_REG_STATUS)
                done <= 1'b0;
            if (go) begin
                op    <= wdata_i[`TWPM_CTRL_OP_HI:`TWPM_CTRL_OP_LO];
                pot   <= wdata_i[`TWPM_CTRL_POT_HI:`TWPM_CTRL_POT_LO];
                data  <= wdata_i[`TWPM_CTRL_DATA_HI:`TWPM_CTRL_DATA_LO];
                busy  <= 1'b1;
                nack  <= 1'b0;
                polls <= 16'h0000;
                sent  <= 1'b0;
                state <= S_START;
            end else if (state == S_WAIT) begin
                // for a poll command, retry until the slave acks or poll_max retries are spent
                if (op == `TWPM_OP_POLL && nack
                        && polls < poll_max) begin
                    polls <= polls + 16'h0001;
                    nack  <= 1'b0;
                    state <= S_START;
                end else begin
                    busy  <= 1'b0;
                    done  <= 1'b1; // set wins over the read clear
                    state <= S_IDLE;
                end
            end else if (state != S_IDLE) begin
                if (!sent && e_ready) begin
                    e_valid <= 1'b1;
                    sent    <= 1'b1;
                end else if (sent && e_ready && !e_valid) begin
                    sent  <= 1'b0;
                    state <= next_state;
                    if ((state == S_ADDR || state == S_INSTR
                            || state == S_DATA || state == S_RADDR)
                            && e_ack)
                        nack <= 1'b1;
                    if (state == S_RBYTE)
                        rbyte <= e_rx;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `TWPM_REG_CTRL:
                    rdata_o <= {data, 2'h0, pot, op, busy};
                `TWPM_REG_STATUS:
                    rdata_o <= {13'h0000, done, nack, busy};
                `TWPM_REG_RDATA:  rdata_o <= {8'h00, rbyte};
                `TWPM_REG_CFG:    rdata_o <= poll_max;
                default:          rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

endmodule // twpm_master

/* File: test/twpm_master_chk.sv */
// bus pin assertions for the two-wire pot master
`timescale 1ns/1ps
`include "twpm_regs.vh"
module twpm_master_chk (
    // clock and register port
    input wire        clk_i,
    input wire        rst_i,
    input wire [3:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    // bus pins
    input wire        sda_i,
    input wire        sda_o,
    input wire        sda_oe_o,
    input wire        scl_o,
    input wire        scl_oe_o
);
    localparam [3:0] TYPE = `TWPM_TYPE_CODE;
    reg [3:0] bitc;
    reg       first;
    reg [7:0] sh;
    reg [9:0] idle;
    // idle saturates well above the longest clock high phase
    always @(posedge clk_i) begin
        if (rst_i) begin
            bitc <= 4'h0;
            first <= 1'b0;
            sh <= 8'h00;
            idle <= 10'h000;
        end else begin
            idle <= !(sda_o && scl_o) ? 10'h000 :
                    (idle == 10'h3FF) ? idle : idle + 10'h001;
            if (scl_o && $fell(sda_o)) begin
                bitc <= 4'h0;
                first <= 1'b1;
            end else if ($rose(scl_o)) begin
                bitc <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
                if (bitc < 4'h8) sh <= {sh[6:0], sda_o};
                if (bitc == 4'h8) first <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence s_start; scl_o && $fell(sda_o); endsequence
    sequence s_stop; scl_o && $rose(sda_o); endsequence
    sequence s_ninth; $rose(scl_o) && bitc == 4'h8; endsequence
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_RESET_IDLE: assert property (
        $fell(rst_i) |-> !sda_oe_o && !scl_oe_o)
        else $error("bus pins driven after reset");
    AST_DATA_HOLD: assert property (
        $rose(scl_o) |-> $stable(sda_o)[*8])
        else $error("data moved while clock high");
    AST_START_FORM: assert property (
        s_start |-> ##1 scl_o[*8])
        else $error("clock fell too soon after start");
    AST_GO_START: assert property (
        wr_i && addr_i == `TWPM_REG_CTRL && wdata_i[0]
        && idle >= 10'h200 |-> ##[1:500] s_start)
        else $error("no start after go");
    AST_STOP_FORM: assert property (
        s_stop |-> (scl_o && sda_o)[*8])
        else $error("bus not idle after stop");
    AST_ADDR_TYPE: assert property (
        $rose(scl_o) && first && bitc < 4'h4
        |-> sda_o == TYPE[2'd3 - bitc[1:0]])
        else $error("wrong type code bit");
    AST_ADDR_SEL: assert property (
        s_ninth ##0 first
        |-> sh[3:1] == `TWPM_SEL_POT || sh[3:1] == `TWPM_SEL_CSR)
        else $error("invalid internal select");
    AST_ADDR_RELEASE: assert property (
        s_ninth ##0 first |-> sda_o)
        else $error("data not released for acknowledge");
    AST_NACK_STOP: assert property (
        s_ninth ##0 (sda_o && sda_i) |-> ##[1:1000] s_stop)
        else $error("no stop after refused byte");
endmodule // twpm_master_chk

bind twpm_master twpm_master_chk twpm_master_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o));

/* File: test/twpm_slave_model.sv */
// behavioural dual pot slave on the two-wire bus
`timescale 1ns/1ps
`include "twpm_regs.vh"
module twpm_slave_model #(
    parameter [3:0] TYPE_CODE = `TWPM_TYPE_CODE, // arbitrary value
    parameter       PROG_NS   = 100000,
    parameter       PON_NS    = 100
) (
    // bus wires
    input  wire scl_i,
    input  wire sda_i,
    output reg  sda_oe_o
);
    reg [7:0] sh, rbyte, csr = 8'h00, nvm1 = 8'h00, nvm2 = 8'h00;
    reg [7:0] wip1 = 8'h00, wip2 = 8'hFF;
    reg       act = 1'b0, tx = 1'b0, txp = 1'b0, pend = 1'b0;
    reg       rd, pot, wt, ack;
    reg [1:0] ptr = 2'h1;
    integer   bi = 0, nb = 0, refused = 0;
    time      busy_until = 0;
    initial begin
        sda_oe_o = 1'b0;
        #(PON_NS);
        wip1 = nvm1;
        wip2 = nvm2;
    end
    ////////////////////////////////////////////////////////////////////
    task decide;
        begin
            ack = 1'b1;
            if (nb == 0) begin
                pot = (sh[3:1] == `TWPM_SEL_POT);
                rd = sh[0];
                ack = sh[7:4] == TYPE_CODE && !($time < busy_until)
                      && (pot || sh[3:1] == `TWPM_SEL_CSR);
                if (!ack) refused = refused + 1;
                rbyte = !pot ? csr : (ptr == 2'h1) ? wip1 : wip2;
                txp = ack && rd;
            end else if (nb == 1 && pot) begin
                ptr = sh[1:0];
                wt = sh[7];
                ack = sh[1:0] != 2'h3 && sh[1:0] != 2'h0;
            end else if (nb == 1) begin
                csr = sh;
                pend = |(sh & 8'h81);
            end else if (nb == 2 && pot && csr[1]) begin
                if (ptr == 2'h1) wip1 = (sh > 8'h63) ? 8'h63 : sh;
                else wip2 = sh; // one step, never two taps off
                if (wt && ptr == 2'h1) nvm1 = wip1;
                if (wt && ptr == 2'h2) nvm2 = wip2;
                pend = wt;
            end
        end
    endtask
    always @(negedge sda_i) begin
        if (scl_i) begin
            act = 1'b1;
            tx = 1'b0;
            txp = 1'b0;
            bi = 0;
            nb = 0;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i) begin
            act = 1'b0;
            if (pend) busy_until = $time + PROG_NS;
            pend = 1'b0;
        end
    end
    // ideal wires here, so edges need no filtering
    always @(posedge scl_i) begin
        if (act && bi < 8) begin
            sh = {sh[6:0], sda_i};
            bi = bi + 1;
        end else if (act) begin
            bi = 0;
            nb = nb + 1;
            tx = txp;
            if (tx && sda_i) act = 1'b0;
        end
    end
    // only moves with the clock low, so never mimics start or stop
    always @(negedge scl_i) begin
        if (act && bi == 8 && tx) begin
            sda_oe_o = 1'b0;
        end else if (act && bi == 8) begin
            decide;
            sda_oe_o = ack;
            if (!ack) act = 1'b0;
        end else if (act) begin
            sda_oe_o = tx && !rbyte[7 - bi];
        end
    end
endmodule // twpm_slave_model

/* File: test/twpm_master_test.sv */
// self-checking bench for the two-wire pot master
`timescale 1ns/1ps
`include "twpm_regs.vh"
module twpm_master_test;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [3:0]  addr_i = 4'h0;
    reg  [15:0] wdata_i = 16'h0000;
    reg         wr_i = 1'b0;
    reg         rd_i = 1'b0;
    wire [15:0] rdata_o;
    wire        sda_o, sda_oe_o, scl_o, scl_oe_o, slv_oe;
    integer     failures = 0;
    integer     check_count = 0;
    reg  [15:0] rv;
    // open drain wires, pulled up when nobody pulls
    wire        scl_w = !scl_oe_o;
    wire        sda_w = !(sda_oe_o || slv_oe);
    always #10 clk_i = !clk_i;
    twpm_master twpm_master_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o));
    // short programming time keeps polling affordable
    twpm_slave_model #(.PROG_NS(100000)) twpm_slave_model_inst (
        .scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(slv_oe));
    ////////////////////////////////////////////////////////////////////
    task chk(input [15:0] got, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task reg_wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task reg_rd(input [3:0] a, output [15:0] d);
        begin
            @(posedge clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            @(negedge clk_i);
            d = rdata_o;
        end
    endtask
    task run_op(input [2:0] op, input [1:0] pot, input [7:0] d, input nk);
        integer n;
        begin
            reg_wr(`TWPM_REG_CTRL, {d, 2'b00, pot, op, 1'b1});
            n = 0;
            rv = 16'h0001;
            while (rv[0] !== 1'b0 && n < 5000) begin
                repeat (20) @(posedge clk_i);
                reg_rd(`TWPM_REG_STATUS, rv);
                n = n + 1;
            end
            chk({13'h0000, rv[2:0]}, {13'h0000, 1'b1, nk, 1'b0});
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_regs;
        begin
            reg_rd(`TWPM_REG_STATUS, rv);
            chk(rv, 16'h0000);
            reg_rd(`TWPM_REG_CFG, rv);
            chk(rv, `TWPM_POLL_MAX);
            reg_wr(`TWPM_REG_CFG, 16'h0040);
            reg_wr(4'hF, 16'hFFFF);
            reg_rd(`TWPM_REG_CFG, rv);
            chk(rv, 16'h0040);
        end
    endtask
    task t_latch_and_volatile;
        begin
            run_op(`TWPM_OP_CS_WRITE, 2'h0, 8'h02, 1'b0);
            chk({15'h0000, twpm_slave_model_inst.csr[1]}, 16'h0001);
            run_op(`TWPM_OP_CS_READ, 2'h0, 8'h00, 1'b0);
            reg_rd(`TWPM_REG_RDATA, rv);
            chk(rv, 16'h0002);
            run_op(`TWPM_OP_VWRITE, `TWPM_POT_100, 8'hC8, 1'b0);
            chk({8'h00, twpm_slave_model_inst.wip1}, 16'h0063);
            chk({8'h00, twpm_slave_model_inst.nvm1}, 16'h0000);
        end
    endtask
    task t_nonvolatile_poll_read;
        begin
            run_op(`TWPM_OP_NVWRITE, `TWPM_POT_256, 8'hA5, 1'b0);
            chk({8'h00, twpm_slave_model_inst.nvm2}, 16'h00A5);
            run_op(`TWPM_OP_POLL, `TWPM_POT_256, 8'h00, 1'b0);
            chk({15'h0000, twpm_slave_model_inst.refused != 0}, 16'h0001);
            run_op(`TWPM_OP_READ, `TWPM_POT_256, 8'h00, 1'b0);
            reg_rd(`TWPM_REG_RDATA, rv);
            chk(rv, 16'h00A5);
        end
    endtask
    task t_reserved_pot;
        begin
            run_op(`TWPM_OP_VWRITE, `TWPM_POT_RSVD, 8'h11, 1'b1);
            chk({8'h00, twpm_slave_model_inst.wip2}, 16'h00A5);
            reg_rd(`TWPM_REG_CTRL, rv);
            chk(rv, 16'h1130);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d failures %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // long idle so the first go sees a quiet bus
        repeat (600) @(posedge clk_i);
        t_regs;
        t_latch_and_volatile;
        t_nonvolatile_poll_read;
        t_reserved_pot;
        finish_test;
    end
    initial begin
        // about 99k cycles; a clean run needs roughly 88k
        #1980000;
        failures = failures + 1;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test;
    end
endmodule // twpm_master_test
